// file: verilog/sdram_pkg.sv
// Command codes, mode fields and timing counts shared by both SDRAM link ends
package sdram_pkg;
  // Link widths
  localparam int DQ_W   = 16;
  localparam int DM_W   = DQ_W / 8;
  localparam int BA_W   = 2;
  localparam int AD_W   = 13;
  localparam int COL_AW = 10;
  localparam int U_AW   = BA_W + AD_W + COL_AW;

  // Clock and times as printed
  localparam int CLK_NS          = 10;
  localparam int T_RAS_NS        = 50;
  localparam int T_RAS_MAX_NS    = 120000;
  localparam int T_RC_SLOW_NS    = 70;
  localparam int T_RC_FAST_NS    = 68;
  localparam int T_RCD_NS        = 20;
  localparam int T_RP_NS         = 20;
  localparam int T_RRD_NS        = 20;
  localparam int T_WR_NS         = 15;
  localparam int T_WR_AP_NS      = 7;
  localparam int T_XSR_NS        = 80;
  localparam int T_RFC_NS        = 70;
  localparam int T_REF_MS        = 64;
  localparam int REF_ROWS        = 8192;
  localparam int T_PWRUP_US      = 100;
  localparam int T_CK_CL2_SLOW_NS = 13;
  localparam int T_CK_CL2_FAST_NS = 10;

  // Least times round up, longest times round down, never below one cycle
  function automatic int cyc_up(int ns);
    return (ns + CLK_NS - 1) / CLK_NS < 1 ? 1 : (ns + CLK_NS - 1) / CLK_NS;
  endfunction
  function automatic int cyc_dn(int ns);
    return ns / CLK_NS < 1 ? 1 : ns / CLK_NS;
  endfunction

  localparam int C_RAS     = cyc_up(T_RAS_NS);
  localparam int C_RAS_MAX = cyc_dn(T_RAS_MAX_NS);
  localparam int C_RC_SLOW = cyc_up(T_RC_SLOW_NS);
  localparam int C_RC_FAST = cyc_up(T_RC_FAST_NS);
  localparam int C_RCD     = cyc_up(T_RCD_NS);
  localparam int C_RP      = cyc_up(T_RP_NS);
  localparam int C_RRD     = cyc_up(T_RRD_NS);
  localparam int C_WR      = cyc_up(T_WR_NS);
  localparam int C_WR_AP   = cyc_up(CLK_NS + T_WR_AP_NS);
  localparam int C_XSR     = cyc_up(T_XSR_NS);
  localparam int C_RFC     = cyc_up(T_RFC_NS);
  localparam int C_REFI    = cyc_dn(T_REF_MS * 1000000 / REF_ROWS);
  localparam int C_PWRUP   = cyc_up(T_PWRUP_US * 1000);
  // Counts given directly in clocks
  localparam int C_DPL      = 2;
  localparam int C_DAL_SLOW = 4;
  localparam int C_DAL_FAST = 5;
  localparam int C_MRD      = 3;
  localparam int C_XSR_NOP  = 2;
  localparam int C_INIT_REF = 2;
  localparam int C_DQZ      = 2;

  // Mode word fields and the auto/all precharge address bit
  localparam int         MR_BL_LSB  = 0;
  localparam int         MR_CAS_LSB = 4;
  localparam int         AP_BIT     = 10;
  localparam logic [2:0] MR_BL_RST  = 3'h0;
  localparam logic [2:0] MR_CAS_RST = 3'h3;

  // Command code as {row strobe, column strobe, write strobe}, all active low
  typedef enum logic [2:0] {
    CMD_MRS = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WR  = 3'h4,
    CMD_RD  = 3'h5,
    CMD_BST = 3'h6,
    CMD_NOP = 3'h7
  } cmd_t;
endpackage

// file: verilog/sdram_link_if.sv
// Command, address, mask and data wires between controller and memory
`timescale 1ns/100ps
interface sdram_link_if;
  import sdram_pkg::*;
  logic              cke;
  logic              cs_n;
  cmd_t              cmd;
  logic [BA_W-1:0]   ba;
  logic [AD_W-1:0]   addr;
  logic [DM_W-1:0]   dqm;
  logic [DQ_W-1:0]   dq_c;
  logic              dq_c_oe;
  logic [DQ_W-1:0]   dq_m;
  logic [DM_W-1:0]   dq_m_oe;

  modport ctrl (output cke, cs_n, cmd, ba, addr, dqm, dq_c, dq_c_oe,
                input  dq_m, dq_m_oe);
  modport mem  (input  cke, cs_n, cmd, ba, addr, dqm, dq_c, dq_c_oe,
                output dq_m, dq_m_oe);
endinterface

// file: verilog/sdram_mem_end.sv
// Memory end of the SDRAM link: decode, banks, bursts and output timing
`timescale 1ns/100ps
module sdram_mem_end #(
  parameter int ROW_W = 4,
  parameter int COL_W = 4
)(
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  sdram_link_if.mem       link,
  output logic            in_self_refresh,
  output logic            clock_suspended,
  output logic [2:0]      cas_latency
);
  import sdram_pkg::*;

  localparam int IDX_W = BA_W + ROW_W + COL_W;

  if (ROW_W < 1 || ROW_W > AD_W || COL_W < 1 || COL_W > COL_AW)
  begin : g_chk
    $error("sdram_mem_end: row or column width out of range");
  end

  function automatic logic [3:0] bl_beats(logic [2:0] code);
    return (code > 3'h3) ? 4'h1 : 4'(1 << code);
  endfunction

  logic [DQ_W-1:0]  mem_q [2**IDX_W];
  logic [ROW_W-1:0] row_q [2**BA_W];
  logic [3:0]       open_q;
  logic             en_q, self_q, susp_q;
  logic [2:0]       cas_q, bl_q;
  logic [3:0]       left_q;
  logic             bwr_q, bap_q;
  logic [BA_W-1:0]  bba_q, ap_ba_q;
  logic [COL_W-1:0] bcol_q;
  logic [1:0]       ap_cnt_q;
  logic             p0_v_q, p1_v_q;
  logic [DQ_W-1:0]  p0_d_q, p1_d_q, dq_q;
  logic [DM_W-1:0]  dqm_q, oe_q;

  // Decode: inputs count only on an edge that CKE left enabled
  logic             cmd_v, is_rw, stop, beat, b_wr, b_last;
  logic [BA_W-1:0]  b_ba;
  logic [COL_W-1:0] b_col;
  logic [IDX_W-1:0] idx;
  assign cmd_v  = en_q && !link.cs_n && !self_q;
  assign is_rw  = cmd_v && (link.cmd == CMD_RD || link.cmd == CMD_WR);
  assign stop   = cmd_v && (link.cmd == CMD_BST || (link.cmd == CMD_PRE
                  && (link.addr[AP_BIT] || link.ba == bba_q)));
  assign beat   = is_rw || (en_q && left_q != 4'h0 && !stop);
  assign b_wr   = is_rw ? (link.cmd == CMD_WR) : bwr_q;
  assign b_ba   = is_rw ? link.ba : bba_q;
  assign b_col  = is_rw ? link.addr[COL_W-1:0] : bcol_q;
  assign b_last = beat && (is_rw ? bl_beats(bl_q) == 4'h1 : left_q == 4'h1);
  assign idx    = {b_ba, row_q[b_ba], b_col};

  // One clock of latency from CKE to suspend or power-down
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      en_q   <= 1'b0;
      susp_q <= 1'b1;
    end
    else
    begin
      en_q   <= link.cke;
      susp_q <= !link.cke;
    end

  // Self refresh: refresh with CKE low enters, CKE high leaves
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      self_q <= 1'b0;
    else if (self_q && link.cke)
      self_q <= 1'b0;
    else if (cmd_v && link.cmd == CMD_REF && !link.cke)
      self_q <= 1'b1;

  // Mode word holds CAS latency and burst length
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      cas_q <= MR_CAS_RST;
      bl_q  <= MR_BL_RST;
    end
    else if (cmd_v && link.cmd == CMD_MRS)
    begin
      cas_q <= link.addr[MR_CAS_LSB +: 3];
      bl_q  <= link.addr[MR_BL_LSB +: 3];
    end

  // Burst sequencer; a new column command takes over the running burst
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      left_q <= 4'h0;
      bwr_q  <= 1'b0;
      bap_q  <= 1'b0;
      bba_q  <= '0;
      bcol_q <= '0;
    end
    else if (is_rw)
    begin
      left_q <= bl_beats(bl_q) - 4'h1;
      bwr_q  <= link.cmd == CMD_WR;
      bap_q  <= link.addr[AP_BIT];
      bba_q  <= link.ba;
      bcol_q <= link.addr[COL_W-1:0] + 1'b1;
    end
    else if (stop)
      left_q <= 4'h0;
    else if (beat)
    begin
      left_q <= left_q - 4'h1;
      bcol_q <= bcol_q + 1'b1;
    end

  // Banks; auto precharge after writes waits one clock plus the recovery slack
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      open_q   <= 4'h0;
      ap_cnt_q <= 2'h0;
      ap_ba_q  <= '0;
      for (int b = 0; b < 2**BA_W; b++)
        row_q[b] <= '0;
    end
    else if (en_q)
    begin
      if (ap_cnt_q != 2'h0)
        ap_cnt_q <= ap_cnt_q - 2'h1;
      if (ap_cnt_q == 2'h1)
        open_q[ap_ba_q] <= 1'b0;
      if (b_last && (is_rw ? link.addr[AP_BIT] : bap_q))
      begin
        ap_ba_q  <= b_ba;
        ap_cnt_q <= b_wr ? 2'(C_WR_AP) : 2'h1;
      end
      if (cmd_v && link.cmd == CMD_ACT)
      begin
        open_q[link.ba] <= 1'b1;
        row_q[link.ba]  <= link.addr[ROW_W-1:0];
      end
      else if (cmd_v && link.cmd == CMD_PRE)
      begin
        if (link.addr[AP_BIT])
          open_q <= 4'h0;
        else
          open_q[link.ba] <= 1'b0;
      end
    end

  // Array write; a mask bit blocks the data of its own cycle
  always_ff @(posedge clk_sys)
    if (beat && b_wr && open_q[b_ba])
      for (int i = 0; i < DM_W; i++)
        if (!link.dqm[i])
          mem_q[idx][8*i +: 8] <= link.dq_c[8*i +: 8];

  // Read pipe; tap chosen by CAS latency, so a precharge ends output that much later
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      p0_v_q <= 1'b0;
      p1_v_q <= 1'b0;
      p0_d_q <= '0;
      p1_d_q <= '0;
      dqm_q  <= '0;
      dq_q   <= '0;
      oe_q   <= '0;
    end
    else if (en_q)
    begin
      p0_v_q <= beat && !b_wr && open_q[b_ba];
      p0_d_q <= mem_q[idx];
      p1_v_q <= p0_v_q;
      p1_d_q <= p0_d_q;
      dqm_q  <= link.dqm;
      // Mask seen one edge ago turns lanes off: two clocks in all
      if (cas_q == 3'h2)
      begin
        dq_q <= p0_d_q;
        oe_q <= p0_v_q ? ~dqm_q : '0;
      end
      else
      begin
        dq_q <= p1_d_q;
        oe_q <= p1_v_q ? ~dqm_q : '0;
      end
    end

  assign link.dq_m       = dq_q;
  assign link.dq_m_oe    = oe_q;
  assign in_self_refresh = self_q;
  assign clock_suspended = susp_q;
  assign cas_latency     = cas_q;
endmodule

// file: verilog/sdram_ctrl_end.sv
// Controller end of the SDRAM link: init, refresh, row cycles and self refresh
`timescale 1ns/100ps
// Overview of operation
// - Row open 50 ns, closed within 120 us
// - Same-bank activations spaced 70 or 68 ns
// - Activate to column command at least 20 ns
// - Precharge to next activate at least 20 ns
// - Activations of different banks 20 ns apart
// - All 8192 rows refreshed every 64 ms
// - Manual precharge two clocks after write data
// - Auto-precharge write: activate 4 or 5 clocks later
// - Auto precharge starts after clock plus 7 ns
// - Self refresh exit to activate 80 ns
// - Column commands may come every clock
// - CKE acts with one clock of latency
// - Write mask blocks same-cycle data
// - Read mask turns outputs off two clocks later
// - Write data travels with the write command
// - Next command one clock after last write data
// - Mode load to activate or refresh: three clocks
// - Precharge ends read output CAS latency later
// - Power-up wait, two refreshes, repeat after lapse
// - CAS latency 2 needs slow enough clock
// - Clock steady during accesses; CKE slows rate
// - No-operations for the self refresh exit interval
module sdram_ctrl_end #(
  parameter int CAS_LAT     = 3,
  parameter bit SLOW_GRADE  = 1'b1,
  parameter bit WR_AUTO_PRE = 1'b1,
  parameter int PWRUP_CYC   = sdram_pkg::C_PWRUP,
  parameter int REFI_CYC    = sdram_pkg::C_REFI
)(
  input  wire logic                   clk_sys,
  input  wire logic                   nrst,
  sdram_link_if.ctrl                  link,
  input  wire logic                   req_valid,
  input  wire logic                   req_write,
  input  wire logic [sdram_pkg::U_AW-1:0] req_addr,
  input  wire logic [sdram_pkg::DQ_W-1:0] req_wdata,
  output logic                        req_ack,
  output logic [sdram_pkg::DQ_W-1:0]  rd_data,
  output logic                        rd_valid,
  input  wire logic                   sleep_req,
  output logic                        asleep,
  output logic                        init_done
);
  import sdram_pkg::*;

  localparam int C_RC     = SLOW_GRADE ? C_RC_SLOW : C_RC_FAST;
  localparam int C_DAL    = SLOW_GRADE ? C_DAL_SLOW : C_DAL_FAST;
  localparam int C_CK_CL2 = SLOW_GRADE ? T_CK_CL2_SLOW_NS : T_CK_CL2_FAST_NS;
  localparam int C_WRP    = C_WR > C_DPL ? C_WR : C_DPL;
  localparam int C_XW     = C_XSR > C_XSR_NOP ? C_XSR : C_XSR_NOP;
  localparam logic [AD_W-1:0] MODE_WORD = AD_W'(CAS_LAT << MR_CAS_LSB);

  // CAS latency 2 only where the clock period allows it
  if (CAS_LAT < 2 || CAS_LAT > 3 || (CAS_LAT == 2 && CLK_NS < C_CK_CL2))
  begin : g_chk_cl
    $error("sdram_ctrl_end: CAS latency not usable at this clock");
  end
  if (PWRUP_CYC < 1 || PWRUP_CYC > 65535 || REFI_CYC < 8 || REFI_CYC > 65535)
  begin : g_chk_cnt
    $error("sdram_ctrl_end: count parameter out of range");
  end

  typedef enum logic [2:0] {
    ST_POWER = 3'h0,
    ST_PALL  = 3'h1,
    ST_IREF  = 3'h2,
    ST_WAIT  = 3'h3,
    ST_IDLE  = 3'h4,
    ST_ACT   = 3'h5,
    ST_RW    = 3'h6,
    ST_SELF  = 3'h7
  } state_t;

  state_t             state_q;
  logic               exiting_q;
  logic [15:0]        wait_q, refi_q;
  logic [3:0]         rc_q, ras_q;
  logic [1:0]         refs_q;
  logic               ref_due_q;
  logic [3:0]         rdp_q;
  logic               cke_q, cs_n_q, ack_q, wr_q, asleep_q, done_q, rdv_q;
  cmd_t               cmd_q;
  logic [BA_W-1:0]    ba_q;
  logic [AD_W-1:0]    addr_q;
  logic [COL_AW-1:0]  col_q;
  logic [DQ_W-1:0]    dq_q, wdata_q, rd_q;
  logic               dq_oe_q;

  // Refresh interval; the tick wins over a refresh that clears it together
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      refi_q    <= 16'h0;
      ref_due_q <= 1'b0;
    end
    else if (refi_q == 16'h0)
    begin
      refi_q    <= 16'(REFI_CYC - 1);
      ref_due_q <= done_q;
    end
    else
    begin
      refi_q <= refi_q - 16'h1;
      if (!cs_n_q && cmd_q == CMD_REF)
        ref_due_q <= 1'b0;
    end

  // Row timers started by the activate on the wires
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      rc_q  <= 4'h0;
      ras_q <= 4'h0;
    end
    else if (!cs_n_q && cmd_q == CMD_ACT)
    begin
      rc_q  <= 4'(C_RC - 2);
      ras_q <= 4'(C_RAS - 2);
    end
    else
    begin
      if (rc_q != 4'h0)
        rc_q <= rc_q - 4'h1;
      if (ras_q != 4'h0)
        ras_q <= ras_q - 4'h1;
    end

  // Read capture CAS latency clocks after the read on the wires
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      rdp_q <= 4'h0;
      rd_q  <= '0;
      rdv_q <= 1'b0;
    end
    else
    begin
      rdp_q <= {rdp_q[2:0], !cs_n_q && cmd_q == CMD_RD};
      rdv_q <= rdp_q[CAS_LAT-1];
      if (rdp_q[CAS_LAT-1])
        rd_q <= link.dq_m;
    end

  // Command sequencer; wait_q counts clocks until the next command may go
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      state_q   <= ST_POWER;
      exiting_q <= 1'b0;
      wait_q    <= 16'(PWRUP_CYC - 1);
      refs_q    <= 2'h0;
      cke_q     <= 1'b1;
      cs_n_q    <= 1'b1;
      cmd_q     <= CMD_NOP;
      ba_q      <= '0;
      addr_q    <= '0;
      col_q     <= '0;
      dq_q      <= '0;
      dq_oe_q   <= 1'b0;
      wdata_q   <= '0;
      wr_q      <= 1'b0;
      ack_q     <= 1'b0;
      asleep_q  <= 1'b0;
      done_q    <= 1'b0;
    end
    else
    begin
      cs_n_q  <= 1'b1;
      cmd_q   <= CMD_NOP;
      dq_oe_q <= 1'b0;
      ack_q   <= 1'b0;
      if (wait_q != 16'h0)
        wait_q <= wait_q - 16'h1;
      unique case (state_q)
        // Power-up pause, then precharge all banks
        ST_POWER:
          if (wait_q == 16'h0)
          begin
            cs_n_q         <= 1'b0;
            cmd_q          <= CMD_PRE;
            addr_q[AP_BIT] <= 1'b1;
            wait_q         <= 16'(C_RP - 1);
            state_q        <= ST_PALL;
          end
        ST_PALL:
          if (wait_q == 16'h0)
          begin
            refs_q  <= 2'(C_INIT_REF);
            state_q <= ST_IREF;
          end
        // Two refreshes, then mode load on first pass only
        ST_IREF:
          if (wait_q == 16'h0)
          begin
            cs_n_q <= 1'b0;
            if (refs_q != 2'h0)
            begin
              cmd_q  <= CMD_REF;
              refs_q <= refs_q - 2'h1;
              wait_q <= 16'(C_RFC - 1);
            end
            else if (done_q)
            begin
              cs_n_q  <= 1'b1;
              state_q <= ST_IDLE;
            end
            else
            begin
              cmd_q   <= CMD_MRS;
              addr_q  <= MODE_WORD;
              wait_q  <= 16'(C_MRD - 1);
              done_q  <= 1'b1;
              state_q <= ST_WAIT;
            end
          end
        ST_WAIT:
          if (wait_q == 16'h0)
            state_q <= ST_IDLE;
        // Refresh first, then sleep, then a user access
        ST_IDLE:
          if (ref_due_q)
          begin
            cs_n_q  <= 1'b0;
            cmd_q   <= CMD_REF;
            wait_q  <= 16'(C_RFC - 1);
            state_q <= ST_WAIT;
          end
          else if (sleep_req)
          begin
            cs_n_q    <= 1'b0;
            cmd_q     <= CMD_REF;
            cke_q     <= 1'b0;
            asleep_q  <= 1'b1;
            exiting_q <= 1'b0;
            wait_q    <= 16'(C_RAS - 1);
            state_q   <= ST_SELF;
          end
          else if (req_valid && rc_q == 4'h0)
          begin
            cs_n_q  <= 1'b0;
            cmd_q   <= CMD_ACT;
            ba_q    <= req_addr[U_AW-1 -: BA_W];
            addr_q  <= req_addr[COL_AW +: AD_W];
            col_q   <= req_addr[COL_AW-1:0];
            wr_q    <= req_write;
            wdata_q <= req_wdata;
            ack_q   <= 1'b1;
            wait_q  <= 16'(C_RCD - 1);
            state_q <= ST_ACT;
          end
        // Column command; write data rides on the same clock
        ST_ACT:
          if (wait_q == 16'h0)
          begin
            cs_n_q         <= 1'b0;
            cmd_q          <= wr_q ? CMD_WR : CMD_RD;
            addr_q         <= AD_W'(col_q);
            addr_q[AP_BIT] <= wr_q && WR_AUTO_PRE;
            dq_q           <= wdata_q;
            dq_oe_q        <= wr_q;
            if (wr_q && WR_AUTO_PRE)
            begin
              wait_q  <= 16'(C_DAL - 1);
              state_q <= ST_WAIT;
            end
            else
            begin
              wait_q  <= wr_q ? 16'(C_WRP - 1) : 16'h0;
              state_q <= ST_RW;
            end
          end
        // Close the row as soon as allowed, far inside the longest open time
        ST_RW:
          if (wait_q == 16'h0 && ras_q == 4'h0)
          begin
            cs_n_q         <= 1'b0;
            cmd_q          <= CMD_PRE;
            addr_q[AP_BIT] <= 1'b0;
            wait_q         <= 16'(C_RP - 1);
            state_q        <= ST_WAIT;
          end
        // Self refresh; on exit only no-operations, then two refreshes
        ST_SELF:
          if (!exiting_q && wait_q == 16'h0 && !sleep_req)
          begin
            cke_q     <= 1'b1;
            exiting_q <= 1'b1;
            wait_q    <= 16'(C_XW - 1);
          end
          else if (exiting_q && wait_q == 16'h0)
          begin
            asleep_q <= 1'b0;
            refs_q   <= 2'(C_INIT_REF);
            state_q  <= ST_IREF;
          end
      endcase
    end

  // Clock runs free throughout; rate is never changed mid-access
  assign link.cke     = cke_q;
  assign link.cs_n    = cs_n_q;
  assign link.cmd     = cmd_q;
  assign link.ba      = ba_q;
  assign link.addr    = addr_q;
  assign link.dqm     = '0;
  assign link.dq_c    = dq_q;
  assign link.dq_c_oe = dq_oe_q;
  assign req_ack      = ack_q;
  assign rd_data      = rd_q;
  assign rd_valid     = rdv_q;
  assign asleep       = asleep_q;
  assign init_done    = done_q;
endmodule

// file: verification/sdram_link_props.sv
// Timing checks on the link between controller end and memory end
`timescale 1ns/100ps
module sdram_link_props
  import sdram_pkg::*;
#(
  parameter int CAS_LAT  = 3,
  parameter int REFI_CYC = C_REFI
)(
  input  wire logic            clk_sys,
  input  wire logic            nrst,
  input  wire logic            cke,
  input  wire logic            cs_n,
  input  wire cmd_t            cmd,
  input  wire logic [AD_W-1:0] addr,
  input  wire logic            dq_c_oe,
  input  wire logic [DM_W-1:0] dq_m_oe
);
  logic act, pre, rd, wr, mrs, rf, busy;

  // A command only counts while the chip is selected
  assign act  = !cs_n && cmd == CMD_ACT;
  assign pre  = !cs_n && cmd == CMD_PRE;
  assign rd   = !cs_n && cmd == CMD_RD;
  assign wr   = !cs_n && cmd == CMD_WR;
  assign mrs  = !cs_n && cmd == CMD_MRS;
  assign rf   = !cs_n && cmd == CMD_REF;
  assign busy = !cs_n && cmd != CMD_NOP;

  // Cycles since the last refresh; self refresh keeps the rows alive by itself
  logic [15:0] ref_age_q;
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      ref_age_q <= 16'h0;
    else if (rf || !cke)
      ref_age_q <= 16'h0;
    else
      ref_age_q <= ref_age_q + 16'h1;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  row_open_a: assert property (act |=> !pre [*4])
    else $error("precharge too soon after activate");
  act_gap_a: assert property (act |=> !act [*6])
    else $error("activates too close");
  act_col_a: assert property (act |=> !(rd || wr))
    else $error("column command too soon after activate");
  pre_act_a: assert property (pre |=> !act)
    else $error("activate too soon after precharge");
  wr_pre_a: assert property (wr |=> !pre)
    else $error("precharge too soon after write data");
  ap_act_a: assert property (wr && addr[AP_BIT] |=> !act [*3])
    else $error("activate too soon after auto precharge write");
  wr_data_a: assert property (wr |-> dq_c_oe)
    else $error("write data missing with write command");
  mode_gap_a: assert property (mrs |=> !busy [*2])
    else $error("command too soon after mode load");
  ref_gap_a: assert property (rf && cke |=> !busy [*6])
    else $error("command too soon after refresh");
  wake_nop_a: assert property ($rose(cke) |-> !busy [*2])
    else $error("command during self refresh exit");
  rd_lat_a: assert property (rd && cke |-> ##CAS_LAT dq_m_oe == 2'h3)
    else $error("read data not driven at cas latency");
  out_src_a: assert property (dq_m_oe != 2'h0 |-> $past(rd, CAS_LAT))
    else $error("read data driven without a read");
  ref_period_a: assert property (ref_age_q < 16'(2 * REFI_CYC))
    else $error("refresh interval overrun");
endmodule

// file: verification/tb.sv
// Self-checking bench: controller end and memory end joined over the link
`timescale 1ns/100ps
module tb;
  import sdram_pkg::*;
  logic              clk_sys   = 1'h0;
  logic              nrst      = 1'h0;
  logic              req_valid = 1'h0;
  logic              req_write = 1'h0;
  logic [U_AW-1:0]   req_addr  = '0;
  logic [DQ_W-1:0]   req_wdata = '0;
  logic              sleep_req = 1'h0;
  logic              req_ack, rd_valid, asleep, init_done;
  logic              in_self_refresh, clock_suspended;
  logic [DQ_W-1:0]   rd_data;
  logic [2:0]        cas_latency;
  int                n_fail = 0;
  int                checks = 0;
  int                cyc    = 0;
  int                seed   = 32'h1b8e;
  logic [DQ_W-1:0]   model [logic [U_AW-1:0]];
  logic [U_AW-1:0]   addrs [$];

  sdram_link_if link ();
  // Short power-up and refresh interval keep the run brief
  sdram_ctrl_end #(.PWRUP_CYC(20), .REFI_CYC(60)) sdram_ctrl_end_inst (
    .clk_sys, .nrst, .link(link.ctrl), .req_valid, .req_write, .req_addr,
    .req_wdata, .req_ack, .rd_data, .rd_valid, .sleep_req, .asleep, .init_done);
  sdram_mem_end sdram_mem_end_inst (.clk_sys, .nrst, .link(link.mem),
    .in_self_refresh, .clock_suspended, .cas_latency);
  sdram_link_props #(.CAS_LAT(3), .REFI_CYC(60)) sdram_link_props_inst (.clk_sys, .nrst,
    .cke(link.cke), .cs_n(link.cs_n), .cmd(link.cmd), .addr(link.addr),
    .dq_c_oe(link.dq_c_oe), .dq_m_oe(link.dq_m_oe));

  always #5 clk_sys = ~clk_sys;

  // Cut a hang short; a refresh storm could otherwise stall forever
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_fail++;
      complete_run();
    end
  end

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Outputs the bench waits on, picked by name so no reference argument is needed
  function automatic logic watched(string what);
    if (what == "req_ack")
      return req_ack;
    else if (what == "rd_valid")
      return rd_valid;
    else
      return asleep;
  endfunction

  // Samples 1 ns after each edge so the edge's updates have landed
  task automatic wait_for(string what, input logic v);
    int n = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    while (watched(what) !== v && n < 400);
    check(what, v, watched(what));
  endtask

  // One user request, held until acknowledged; reads compared with the model
  task automatic access(input logic wr, input logic [U_AW-1:0] a);
    @(posedge clk_sys);
    #1;
    req_valid = 1'h1;
    req_write = wr;
    req_addr  = a;
    req_wdata = $random(seed);
    wait_for("req_ack", 1'h1);
    check("init_done", 1'h1, init_done);
    req_valid = 1'h0;
    if (wr)
      model[a] = req_wdata;
    else
    begin
      wait_for("rd_valid", 1'h1);
      check("rd_data", model[a], rd_data);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    logic [31:0]     r;
    logic [U_AW-1:0] a;
    repeat (12) @(posedge clk_sys);
    #1;
    nrst = 1'h1;
    // Random writes inside the stored address bits, then read back
    repeat (16)
    begin
      r = $random(seed);
      a = '0;
      a[24:23] = r[1:0];
      a[13:10] = r[5:2];
      a[3:0]   = r[9:6];
      access(1'h1, a);
      addrs.push_back(a);
    end
    foreach (addrs[i]) access(1'h0, addrs[i]);
    check("cas_latency", 3'h3, cas_latency);
    // Self refresh: clock enable low must leave the memory suspended three clocks after asleep
    @(posedge clk_sys);
    #1;
    sleep_req = 1'h1;
    wait_for("asleep", 1'h1);
    repeat (3) @(posedge clk_sys);
    #1;
    check("cke", 1'h0, link.cke);
    check("clock_suspended", 1'h1, clock_suspended);
    check("in_self_refresh", 1'h1, in_self_refresh);
    repeat (10) @(posedge clk_sys);
    #1;
    sleep_req = 1'h0;
    wait_for("asleep", 1'h0);
    check("in_self_refresh", 1'h0, in_self_refresh);
    // Contents must survive self refresh
    foreach (addrs[i]) access(1'h0, addrs[i]);
    complete_run();
  end
endmodule
